// [src/eeslv_map.svh]
`ifndef EESLV_MAP_SVH
`define EESLV_MAP_SVH

// -----------------------------------------------------------------
// Select byte layout and timing
// -----------------------------------------------------------------
`define EESLV_DEV_CODE      4'h5
`define EESLV_SEL_CODE_HI   7
`define EESLV_SEL_CODE_LO   4
`define EESLV_SEL_CE_HI     3
`define EESLV_SEL_CE_LO     1
`define EESLV_SEL_RW        0
`define EESLV_MULTI_BYTES   4
`define EESLV_PAGE_BYTES    8
`define EESLV_PROG_TIME_NS  10000
`define EESLV_CLK_NS        4
`define EESLV_PROG_CYCLES   ((`EESLV_PROG_TIME_NS + `EESLV_CLK_NS - 1) / `EESLV_CLK_NS)
`endif

// [src/eeslv_pkg.sv]
package eeslv_pkg;
    // Serial engine states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SEL  = 7'h02,
        ST_ADDR = 7'h04,
        ST_WDAT = 7'h08,
        ST_RDAT = 7'h10,
        ST_ACK  = 7'h20,
        ST_RACK = 7'h40
    } eeslv_state_t;
endpackage

// [src/eeslv_mem.sv]
// -----------------------------------------------------------------
// Byte array with registered read and a two-entry write buffer
// -----------------------------------------------------------------
module eeslv_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Write stream in
    input  wire logic          wr_valid,
    output logic               wr_ready,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    typedef struct packed {
        logic [1:0]          full;   // Buffer entry valid
        logic [1:0][AW-1:0]  a;      // Buffered addresses
        logic [1:0][DW-1:0]  d;      // Buffered data
        logic [DW-1:0]       q;      // Registered read data
    } eeslv_mst_t;
    eeslv_mst_t s, next_s;
    logic [DW-1:0] arr [0:(1<<AW)-1];  // Cell array
    logic          drain;              // Head entry committed this cycle

    assign wr_ready = ~s.full[1];
    assign rd_data  = s.q;
    assign drain    = s.full[0];

    // Buffer shifting: head drains one per cycle, tail fills from input
    always_comb begin
        next_s   = s;
        next_s.q = arr[rd_addr];
        if (drain) begin
            next_s.full = {1'b0, s.full[1]};
            next_s.a[0] = s.a[1];
            next_s.d[0] = s.d[1];
        end
        if (wr_valid && wr_ready) begin
            if (next_s.full[0]) begin
                next_s.full[1] = 1'b1;
                next_s.a[1]    = wr_addr;
                next_s.d[1]    = wr_data;
            end else begin
                next_s.full[0] = 1'b1;
                next_s.a[0]    = wr_addr;
                next_s.d[0]    = wr_data;
            end
        end
        if (rst) begin
            next_s.full = 2'b00;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // Array write, no reset on purpose: contents are nonvolatile
    always_ff @(posedge clk) begin
        if (drain) begin
            arr[s.a[0]] <= s.d[0];
        end
    end
endmodule

// [src/eeslv_top.sv]
`include "eeslv_map.svh"
// -----------------------------------------------------------------
// Serial EEPROM slave front end
// -----------------------------------------------------------------
module eeslv_top
    import eeslv_pkg::*;
#(
    parameter bit          PROTECT_VARIANT = 1'b0,
    parameter int unsigned PROG_CYCLES     = `EESLV_PROG_CYCLES
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Power-on reset hold
    input  wire logic POR,
    // Two-wire bus
    input  wire logic SCL,
    input  wire logic SDA_IN,
    output logic      SDA_OUT,
    output logic      SDA_OE_N,
    // Chip enables
    input  wire logic SELECT_PIN_LSB,
    input  wire logic SELECT_PIN_MID,
    input  wire logic SELECT_PIN_MSB,
    // Mode and protection
    input  wire logic MODE,
    input  wire logic WRITE_PROTECT_PIN,
    // Status
    output logic      BUSY
);
    import eeslv_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]   scl_s;     // SCL synchroniser
        logic [1:0]   sda_s;     // SDA synchroniser
        logic         scl_d;     // Previous synced SCL
        logic         sda_d;     // Previous synced SDA
        eeslv_state_t st;        // Engine state
        eeslv_state_t after_ack; // State to enter after ack slot
        logic [2:0]   bitn;      // Bit counter
        logic         got8;      // Eighth bit of a byte sampled
        logic [7:0]   sh;        // Shift register
        logic [7:0]   ptr;       // Address pointer
        logic         rnw;       // Direction of this transaction
        logic         wrote;     // Write data accepted
        logic         nacked;    // Master said no-ack
        logic         drive;     // Pull SDA low
        logic [3:0]   cnt;       // Bytes in this write
        logic [3:0]   grp;       // Group size chosen at select
        logic         prot;      // Protection sampled at select
        logic [31:0]  prog;      // Programming timer
        logic         busy;      // Programming in progress
        logic         wv;        // Write to buffer valid
        logic [7:0]   wa;        // Write address
        logic [7:0]   wd;        // Write data
    } eeslv_top_t;
    eeslv_top_t s, next_s;

    logic       rise, fall, start, stop;   // Bus events
    logic       sel_ok;                    // Select byte matches
    logic [7:0] byte_in;                   // Byte just completed
    logic       wr_ready;                  // Buffer can take a byte
    logic [7:0] rd_data;                   // Array byte at pointer
    logic [7:0] grp_mask;                  // Address bits that wrap in a group

    // Edges and conditions from synced pins only
    assign rise    = s.scl_s[1] & ~s.scl_d;
    assign fall    = ~s.scl_s[1] & s.scl_d;
    assign start   = s.scl_s[1] & s.scl_d & s.sda_d & ~s.sda_s[1];
    assign stop    = s.scl_s[1] & s.scl_d & ~s.sda_d & s.sda_s[1];
    assign byte_in = {s.sh[6:0], s.sda_s[1]};
    // Judged on the fall after the eighth rise, so the whole byte sits in sh
    assign sel_ok  = (s.sh[`EESLV_SEL_CODE_HI:`EESLV_SEL_CODE_LO] == `EESLV_DEV_CODE)
                   && (s.sh[`EESLV_SEL_CE_HI:`EESLV_SEL_CE_LO] ==
                       {SELECT_PIN_MSB, SELECT_PIN_MID, SELECT_PIN_LSB});
    assign grp_mask = 8'(s.grp) - 8'h01;

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.scl_s = {s.scl_s[0], SCL};
        next_s.sda_s = {s.sda_s[0], SDA_IN};
        next_s.scl_d = s.scl_s[1];
        next_s.sda_d = s.sda_s[1];
        // Write request holds until the buffer takes it
        if (s.wv && wr_ready) begin
            next_s.wv = 1'b0;
        end
        // Programming timer; bus is deaf meanwhile
        if (s.busy) begin
            if (s.prog <= 32'd1) begin
                next_s.busy = 1'b0;
            end
            next_s.prog = s.prog - 32'd1;
        end else if (stop) begin
            // Stop ends any transfer
            next_s.st    = ST_IDLE;
            next_s.drive = 1'b0;
            if (s.wrote && !s.rnw && !s.prot) begin
                next_s.busy = 1'b1;
                next_s.prog = PROG_CYCLES;
            end
            next_s.wrote = 1'b0;
            if (s.rnw && !s.nacked) begin
                next_s.drive = 1'b0;
            end
        end else if (start) begin
            // Start or restart reopens select phase from any state when not programming
            next_s.st    = ST_SEL;
            next_s.bitn  = 3'd0;
            next_s.got8  = 1'b0;
            next_s.drive = 1'b0;
            next_s.wrote = 1'b0;
            next_s.nacked = 1'b0;
        end else begin
            case (s.st)
                ST_IDLE: begin
                    next_s.drive = 1'b0;
                end
                ST_SEL, ST_ADDR, ST_WDAT: begin
                    // Shift in MSB first on rising SCL
                    if (rise) begin
                        next_s.sh   = byte_in;
                        next_s.bitn = s.bitn + 3'd1;
                        // Counter wraps to zero, so the fall after START needs this
                        next_s.got8 = (s.bitn == 3'd7);
                    end
                    if (fall && s.got8) begin
                        next_s.got8      = 1'b0;
                        next_s.after_ack = ST_IDLE;
                        if (s.st == ST_SEL) begin
                            if (sel_ok) begin
                                next_s.rnw  = s.sh[`EESLV_SEL_RW];
                                next_s.prot = WRITE_PROTECT_PIN;
                                next_s.grp  = (MODE && !PROTECT_VARIANT)
                                            ? 4'(`EESLV_MULTI_BYTES)
                                            : 4'(`EESLV_PAGE_BYTES);
                                next_s.cnt  = 4'd0;
                                next_s.after_ack = s.sh[`EESLV_SEL_RW] ? ST_RDAT : ST_ADDR;
                            end
                        end else if (s.st == ST_ADDR) begin
                            next_s.ptr = s.sh;
                            next_s.after_ack = ST_WDAT;
                        end else begin
                            // Extra bytes beyond the group are not acked
                            if (s.cnt < s.grp) begin
                                next_s.wv    = !s.prot;
                                next_s.wa    = s.ptr;
                                next_s.wd    = s.sh;
                                next_s.wrote = 1'b1;
                                next_s.cnt   = s.cnt + 4'd1;
                                next_s.ptr   = (s.ptr & ~grp_mask)
                                             | ((s.ptr + 8'h01) & grp_mask);
                                next_s.after_ack = ST_WDAT;
                            end
                        end
                        next_s.drive = (next_s.after_ack != ST_IDLE);
                        next_s.st    = (next_s.after_ack != ST_IDLE) ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    // Release after ninth clock, start read data if needed
                    if (fall) begin
                        next_s.st   = s.after_ack;
                        next_s.bitn = 3'd0;
                        next_s.drive = 1'b0;
                        if (s.after_ack == ST_RDAT) begin
                            next_s.sh    = rd_data;
                            next_s.drive = ~rd_data[7];
                        end
                    end
                end
                ST_RDAT: begin
                    // Shift out on falling SCL, MSB first
                    if (fall) begin
                        next_s.bitn = s.bitn + 3'd1;
                        if (s.bitn == 3'd7) begin
                            next_s.drive = 1'b0;
                            next_s.st    = ST_RACK;
                            next_s.ptr   = s.ptr + 8'h01;
                        end else begin
                            next_s.sh    = {s.sh[6:0], 1'b0};
                            next_s.drive = ~s.sh[6];
                        end
                    end
                end
                ST_RACK: begin
                    // Master ack continues, no-ack waits for stop
                    if (rise) begin
                        next_s.nacked = s.sda_s[1];
                    end
                    if (fall) begin
                        if (s.nacked) begin
                            next_s.st = ST_IDLE;
                        end else begin
                            next_s.st    = ST_RDAT;
                            next_s.bitn  = 3'd0;
                            next_s.sh    = rd_data;
                            next_s.drive = ~rd_data[7];
                        end
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                end
            endcase
        end
        // Power-on reset holds the engine idle and SDA released; a running programming timer and BUSY carry on
        if (RST || POR) begin
            next_s.st    = ST_IDLE;
            next_s.drive = 1'b0;
            next_s.wrote = 1'b0;
            next_s.wv    = 1'b0;
            next_s.nacked = 1'b0;
        end
        if (RST) begin
            next_s.busy  = 1'b0;
            next_s.prog  = 32'd0;
            next_s.ptr   = 8'h00;
            next_s.scl_s = 2'b11;
            next_s.sda_s = 2'b11;
            next_s.scl_d = 1'b1;
            next_s.sda_d = 1'b1;
            next_s.bitn  = 3'd0;
            next_s.got8  = 1'b0;
            next_s.cnt   = 4'd0;
            next_s.grp   = 4'(`EESLV_MULTI_BYTES);
            next_s.prot  = 1'b0;
            next_s.rnw   = 1'b0;
            next_s.sh    = 8'h00;
            next_s.wa    = 8'h00;
            next_s.wd    = 8'h00;
            next_s.after_ack = ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    // Open-drain: data low only, enable low while pulling
    always_ff @(posedge CLK) begin
        SDA_OUT  <= 1'b0;
        SDA_OE_N <= ~next_s.drive;
        BUSY     <= next_s.busy;
    end

    // Cell array with write buffer
    eeslv_mem #(
        .AW (8),
        .DW (8)
    ) u_mem (
        .clk      (CLK),
        .rst      (RST),
        .wr_valid (s.wv),
        .wr_ready (wr_ready),
        .wr_addr  (s.wa),
        .wr_data  (s.wd),
        .rd_addr  (s.ptr),
        .rd_data  (rd_data)
    );
endmodule

// [verification/eeslv_top_monitor.sv]
// --------------------------------------------
// Checker for the serial slave front end
// --------------------------------------------
module eeslv_top_monitor #(
    parameter int unsigned PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus side
    input wire logic POR,
    input wire logic SCL,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    // Protection and status
    input wire logic WRITE_PROTECT_PIN,
    input wire logic BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Length of the current busy stretch, cleared whenever idle
    logic [15:0] busy_len;
    always_ff @(posedge CLK) begin
        if (RST || !BUSY) begin
            busy_len <= 16'h0000;
        end else begin
            busy_len <= busy_len + 16'h0001;
        end
    end

    chk_open_drain: assert property (!SDA_OE_N |-> SDA_OUT == 1'b0)
        else $error("data line driven high");
    chk_pull_scl_low: assert property ($fell(SDA_OE_N) |-> !SCL)
        else $error("pull began while clock high");
    chk_pull_holds: assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*7])
        else $error("pull dropped too early");
    chk_steady_high: assert property (SCL [*5] |-> $stable(SDA_OE_N))
        else $error("data changed while clock high");
    chk_busy_quiet: assert property (BUSY |-> SDA_OE_N)
        else $error("bus driven while programming");
    chk_busy_min: assert property ($rose(BUSY) |=> BUSY [*7])
        else $error("programming cut short");
    chk_busy_length: assert property ($fell(BUSY) |->
        busy_len >= PROG_CYCLES && busy_len <= PROG_CYCLES + 1)
        else $error("programming length off");
    chk_protect_block: assert property ($rose(BUSY) |-> !WRITE_PROTECT_PIN)
        else $error("programming while protected");
    chk_por_silent: assert property (POR [*4] |-> SDA_OE_N && !BUSY)
        else $error("activity during power-on hold");

    // Main scenarios reached
    cover property ($rose(BUSY));
    cover property ($fell(SDA_OE_N));
    cover property (WRITE_PROTECT_PIN && $fell(SDA_OE_N));
endmodule

bind eeslv_top eeslv_top_monitor #(
    .PROG_CYCLES(PROG_CYCLES)
) i_eeslv_top_monitor (
    .CLK, .RST, .POR, .SCL, .SDA_OUT, .SDA_OE_N, .WRITE_PROTECT_PIN, .BUSY
);

// [verification/eeslv_master.sv]
// --------------------------------------------
// Two-wire bus master model
// --------------------------------------------
module eeslv_master #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic clk,
    // Resolved data line
    input  wire logic sda,
    // Driven lines
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: clock high and still, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // START or repeated START, clock low on exit
    task automatic start();
        tick(3);
        sda_pull <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask

    // STOP, bus left idle
    task automatic stop();
        tick(3);
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b0;
        tick(HALF);
    endtask

    // Data moves a few cycles after the fall, so it never looks like START or STOP
    task automatic put(input logic b);
        tick(3);
        sda_pull <= !b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask

    // Sample in mid high phase, well clear of the slave's sync latency
    task automatic get(output logic b);
        tick(3);
        sda_pull <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF / 2);
        b = sda;
        tick(HALF - HALF / 2);
        scl <= 1'b0;
    endtask

    // Byte out, most significant bit first, returns acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put(d[i]);
        end
        get(b);
        ack = !b;
    endtask

    // Byte in, then acknowledge or not
    task automatic recv(output logic [7:0] d, input logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get(b);
            d[i] = b;
        end
        put(!ack);
    endtask
endmodule

// [verification/tb_eeslv_top.sv]
`include "eeslv_map.svh"
module tb_eeslv_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic       por  = 1'b0;
    logic       mode = 1'b1;
    logic       wp   = 1'b0;
    logic [2:0] ce   = 3'h5;
    logic       scl, m_pull, sda, sda_out, oe_n, busy, ack;
    logic [7:0] mem [256];   // Expected array contents
    logic [7:0] ptr;         // Expected read pointer
    int         err_total = 0;
    int         checked   = 0;
    int         cyc       = 0;

    eeslv_top #(.PROG_CYCLES(20)) i_eeslv_top (
        .CLK(clk), .RST(rst), .POR(por), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(oe_n), .SELECT_PIN_LSB(ce[0]), .SELECT_PIN_MID(ce[1]),
        .SELECT_PIN_MSB(ce[2]), .MODE(mode), .WRITE_PROTECT_PIN(wp), .BUSY(busy));
    eeslv_master i_eeslv_master (.clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));
    // Wired-AND data line with pull-up
    assign sda = (oe_n | sda_out) & !m_pull;

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic sel(input logic [3:0] code, input logic [2:0] c, input logic rw,
                       input logic exp);
        i_eeslv_master.start();
        i_eeslv_master.send({code, c, rw}, ack);
        chk("select ack", {7'h00, ack}, {7'h00, exp});
    endtask

    // Write n bytes; bytes past the group are refused and not stored
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
        int         grp;
        logic [7:0] wa;
        logic       seen;
        sel(`EESLV_DEV_CODE, ce, 1'b0, 1'b1);
        grp = mode ? `EESLV_MULTI_BYTES : `EESLV_PAGE_BYTES;
        i_eeslv_master.send(a, ack);
        chk("address ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            wa = (a & ~8'(grp - 1)) | ((a + 8'(i)) & 8'(grp - 1));
            i_eeslv_master.send(d0 + 8'(i), ack);
            chk("data ack", {7'h00, ack}, {7'h00, i < grp});
            if (i < grp && !wp) begin
                mem[wa] = d0 + 8'(i);
            end
        end
        i_eeslv_master.stop();
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            seen = seen | (busy === 1'b1);
        end
        chk("programming seen", {7'h00, seen}, {7'h00, !wp});
        for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
        chk("busy cleared", {7'h00, busy}, 8'h00);
    endtask

    // Random (rnd) or current-address read of n bytes, last one not acknowledged
    task automatic rd(input logic [7:0] a, input int n, input logic rnd);
        logic [7:0] d;
        if (rnd) begin
            sel(`EESLV_DEV_CODE, ce, 1'b0, 1'b1);
            i_eeslv_master.send(a, ack);
            ptr = a;
        end
        sel(`EESLV_DEV_CODE, ce, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_eeslv_master.recv(d, i < n - 1);
            chk("read data", d, mem[ptr]);
            ptr++;
        end
        i_eeslv_master.stop();
    endtask

    task automatic wrap_up();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 18k cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        wr(8'h10, 1, 8'hA0);
        mode <= 1'b0;
        wr(8'h20, 1, 8'hB0);
        mode <= 1'b1;
        wr(8'h43, 5, 8'hC0);
        mode <= 1'b0;
        wr(8'h6D, 9, 8'hD0);
        wr(8'hFF, 1, 8'hE1);
        wr(8'h00, 1, 8'hE2);
        rd(8'h40, 4, 1'b1);
        rd(8'h68, 7, 1'b1);
        rd(8'h00, 1, 1'b0);
        rd(8'hFF, 2, 1'b1);
        rd(8'h10, 1, 1'b1);
        rd(8'h20, 1, 1'b1);
        wp <= 1'b1;
        wr(8'h10, 1, 8'h55);
        wp <= 1'b0;
        rd(8'h10, 1, 1'b1);
        sel(`EESLV_DEV_CODE, ce ^ 3'h1, 1'b0, 1'b0);
        i_eeslv_master.stop();
        sel(`EESLV_DEV_CODE ^ 4'h8, ce, 1'b0, 1'b0);
        i_eeslv_master.stop();
        ce <= 3'h2;
        @(posedge clk);
        wr(8'h30, 1, 8'h77);
        rd(8'h30, 1, 1'b1);
        por <= 1'b1;
        sel(`EESLV_DEV_CODE, ce, 1'b0, 1'b0);
        i_eeslv_master.stop();
        por <= 1'b0;
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule
